/* File: core/lcd_ctrl.sv */
// Purpose: Drive control of a dot-matrix LCD with partial display, sleep and standby.
// Assumes: AHB-Lite single word transfers; zero wait states; responses always OKAY.
// Notes:   The rules carried by this block are listed below.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none

module lcd_ctrl #(
    parameter int unsigned OSC_SETTLE_CLKS = 1024
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    // Panel drive
    output logic [127:0]      row_drive_outputs,
    output logic              drive_enable,
    output logic              drive_power_on,
    output logic [2:0]        bias_code,
    output logic [1:0]        boost_code,
    output logic [5:0]        contrast_code,
    output logic              osc_running
);

    // ****************************************************************
    // Parameters and state
    // ****************************************************************
    localparam int unsigned SETTLE_W = $clog2(OSC_SETTLE_CLKS + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(OSC_SETTLE_CLKS - 1);

    if (OSC_SETTLE_CLKS < 1 || OSC_SETTLE_CLKS > 65535)
    begin : g_bad_settle
        $error("OSC_SETTLE_CLKS must lie between 1 and 65535.");
    end

    typedef struct packed {
        logic                ready;
        logic                resp;
        logic                wr_pend;
        logic [11:0]         wr_addr;
        logic [31:0]         rdata;
        logic [3:0]          duty;
        logic [2:0]          bias;
        logic [1:0]          boost;
        logic                center;
        logic [5:0]          contrast;
        logic                doze;
        logic                halt;
        logic [1:0]          amp;
        logic                osc_run;
        logic                osc_stable;
        logic [SETTLE_W-1:0] settle;
        logic [8:0]          osc_div;
        logic                osc_tick;
        logic                drive_en;
        logic                pwr_on;
        logic                frame_odd;
        logic [127:0]        row_sel;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_RST = '{
        ready:      1'b1,
        duty:       lcd_pkg::DUTY_FULL,
        bias:       lcd_pkg::BIAS_NORMAL,
        boost:      lcd_pkg::BOOST_X6,
        contrast:   lcd_pkg::CONTRAST_RST,
        amp:        lcd_pkg::AMP_RST,
        osc_run:    1'b1,
        osc_stable: 1'b1,
        pwr_on:     1'b1,
        default:    '0
    };

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;
    logic        take;
    logic        locked;
    logic [6:0]  band_start;
    logic [6:0]  phys_row;
    logic [7:0]  nrows;
    logic [31:0] rword;

    scan_if sc ();

    row_scan u_row_scan (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sc      (sc.gen)
    );

    assign nrows        = lcd_pkg::duty_rows(st_r.duty);
    assign sc.tick      = st_r.osc_tick;
    assign sc.enable    = st_r.drive_en;
    assign sc.nrows     = nrows;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.osc_tick = 1'b0;
        take   = hsel && hready && htrans[1] && (hsize == lcd_pkg::SIZE_WORD);
        // While halted and until the restarted oscillator is stable, only the command register is honoured.
        locked = st_r.halt && !st_r.osc_stable;

        // Oscillator stops completely from the halt write until the start command, which restarts it even while halted.
        if (st_r.osc_run)
        begin
            if (st_r.osc_div == lcd_pkg::OSC_DIV_LAST)
            begin
                st_nxt.osc_div  = 9'h000;
                st_nxt.osc_tick = 1'b1;
            end
            else
            begin
                st_nxt.osc_div = st_r.osc_div + 9'h001;
            end
            if (!st_r.osc_stable)
            begin
                if (st_r.settle == SETTLE_LAST)
                    st_nxt.osc_stable = 1'b1;
                else
                    st_nxt.settle = st_r.settle + SETTLE_W'(1);
            end
        end
        else
        begin
            st_nxt.osc_div = 9'h000;
        end

        if (st_r.wr_pend)
        begin
            if (st_r.wr_addr == lcd_pkg::ADDR_CMD)
            begin
                if (hwdata[lcd_pkg::START_OSC_BIT] && !st_r.osc_run)
                begin
                    st_nxt.osc_run = 1'b1;
                    st_nxt.settle  = '0;
                end
            end
            else if (locked)
            begin
                st_nxt.osc_div = st_nxt.osc_div;
            end
            else if (st_r.wr_addr == lcd_pkg::ADDR_DRIVE)
            begin
                st_nxt.duty     = hwdata[lcd_pkg::DUTY_LSB +: 4];
                st_nxt.bias     = hwdata[lcd_pkg::BIAS_LSB +: 3];
                st_nxt.boost    = hwdata[lcd_pkg::BOOST_LSB +: 2];
                st_nxt.center   = hwdata[lcd_pkg::CENTER_BIT];
                st_nxt.contrast = hwdata[lcd_pkg::CONTRAST_LSB +: 6];
            end
            else if (st_r.wr_addr == lcd_pkg::ADDR_POWER)
            begin
                st_nxt.doze = hwdata[lcd_pkg::DOZE_BIT];
                st_nxt.halt = hwdata[lcd_pkg::HALT_BIT];
                st_nxt.amp  = hwdata[lcd_pkg::AMP_LSB +: 2];
                if (hwdata[lcd_pkg::HALT_BIT])
                begin
                    st_nxt.osc_run    = 1'b0;
                    st_nxt.osc_stable = 1'b0;
                end
            end
        end

        // Drive resumes from the stored settings once doze and halt are both gone.
        st_nxt.drive_en = !st_nxt.doze && !st_nxt.halt && st_nxt.osc_stable;
        st_nxt.pwr_on   = !((st_nxt.doze || st_nxt.halt) && st_nxt.amp == lcd_pkg::AMP_OFF);
        if (sc.frame_strobe)
            st_nxt.frame_odd = !st_r.frame_odd;

        // The band sits at the top, or is centred on the full screen.
        band_start = 7'h00;
        if (st_r.center && nrows < lcd_pkg::FULL_ROWS)
            band_start = 7'((lcd_pkg::FULL_ROWS - nrows) >> 1);
        phys_row = band_start + sc.row;
        // Only the scanned row is selected; all others sit at the unselected level.
        // A row left over from a longer scan is never shown, so a duty change cannot leak outside the band.
        st_nxt.row_sel = '0;
        for (int i = 0; i < lcd_pkg::PANEL_ROWS; i++)
        begin
            if (st_r.drive_en && st_nxt.drive_en && ({1'b0, sc.row} < nrows) && phys_row == 7'(i))
                st_nxt.row_sel[i] = 1'b1;
        end

        // Drive and power read data reflect a write finishing in the same cycle; status shows the registered state.
        rword = '0;
        if (haddr[11:0] == lcd_pkg::ADDR_DRIVE)
        begin
            rword[lcd_pkg::DUTY_LSB +: 4]     = st_nxt.duty;
            rword[lcd_pkg::BIAS_LSB +: 3]     = st_nxt.bias;
            rword[lcd_pkg::BOOST_LSB +: 2]    = st_nxt.boost;
            rword[lcd_pkg::CENTER_BIT]        = st_nxt.center;
            rword[lcd_pkg::CONTRAST_LSB +: 6] = st_nxt.contrast;
        end
        else if (haddr[11:0] == lcd_pkg::ADDR_POWER)
        begin
            rword[lcd_pkg::DOZE_BIT]     = st_nxt.doze;
            rword[lcd_pkg::HALT_BIT]     = st_nxt.halt;
            rword[lcd_pkg::AMP_LSB +: 2] = st_nxt.amp;
        end
        else if (haddr[11:0] == lcd_pkg::ADDR_STATUS)
        begin
            rword[lcd_pkg::ST_OSC_RUN]      = st_r.osc_run;
            rword[lcd_pkg::ST_OSC_STABLE]   = st_r.osc_stable;
            rword[lcd_pkg::ST_DRIVE]        = st_r.drive_en;
            rword[lcd_pkg::ST_POWER]        = st_r.pwr_on;
            rword[lcd_pkg::ST_FRAME]        = st_r.frame_odd;
            rword[lcd_pkg::ST_ROW_LSB +: 7] = sc.row;
        end

        st_nxt.wr_pend = take && hwrite;
        st_nxt.wr_addr = haddr[11:0];
        st_nxt.rdata   = (take && !hwrite) ? rword : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= CTRL_RST;
        else
            st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hreadyout         = st_r.ready;
    assign hresp             = st_r.resp;
    assign hrdata            = st_r.rdata;
    assign row_drive_outputs = st_r.row_sel;
    assign drive_enable      = st_r.drive_en;
    assign drive_power_on    = st_r.pwr_on;
    assign bias_code         = st_r.bias;
    assign boost_code        = st_r.boost;
    assign contrast_code     = st_r.contrast;
    assign osc_running       = st_r.osc_run;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_drive;
    assign wr_drive = st_r.wr_pend && !locked && st_r.wr_addr == lcd_pkg::ADDR_DRIVE;

    chk_duty_band: assert property (
        (wr_drive && hwdata[lcd_pkg::DUTY_LSB +: 4] == lcd_pkg::DUTY_BAND) |=> sc.nrows == 8'h10)
        else $error("Band duty did not give a 16-row scan.");
    chk_bias_write: assert property (
        wr_drive |=> bias_code == $past(hwdata[lcd_pkg::BIAS_LSB +: 3]))
        else $error("Bias output does not follow the written field.");
    chk_boost_write: assert property (
        wr_drive |=> boost_code == $past(hwdata[lcd_pkg::BOOST_LSB +: 2]))
        else $error("Boost output does not follow the written field.");
    chk_band_center: assert property (
        (st_r.duty == lcd_pkg::DUTY_BAND && st_r.center) |=>
            ((row_drive_outputs >> lcd_pkg::BAND_CENTER) >> lcd_pkg::BAND_ROWS) == '0 &&
            (row_drive_outputs << (lcd_pkg::PANEL_ROWS - lcd_pkg::BAND_CENTER)) == '0)
        else $error("Centred band selected a row outside it.");
    chk_band_top: assert property (
        (st_r.duty == lcd_pkg::DUTY_BAND && !st_r.center) |=> (row_drive_outputs >> lcd_pkg::BAND_ROWS) == '0)
        else $error("Top band selected a row outside it.");
    chk_doze_ground: assert property (
        st_r.doze |-> row_drive_outputs == '0 && !drive_enable && (osc_running || st_r.halt))
        else $error("Doze left outputs driven or stopped the oscillator.");
    chk_halt_osc: assert property (
        !st_r.osc_run |=> !st_r.osc_tick [*3])
        else $error("Oscillator ticked while stopped.");
    chk_halt_ground: assert property (
        st_r.halt |-> !drive_enable && row_drive_outputs == '0)
        else $error("Deep halt left outputs driven.");
    chk_power_off: assert property (
        (st_r.doze || st_r.halt) && st_r.amp == lcd_pkg::AMP_OFF |-> !drive_power_on)
        else $error("Drive power stayed on with amp code zero.");
    chk_halt_ignore: assert property (
        (locked && st_r.wr_pend && st_r.wr_addr != lcd_pkg::ADDR_CMD) |=>
            $stable(st_r.duty) && $stable(st_r.halt) && $stable(st_r.contrast))
        else $error("Write accepted while halted.");
    chk_contrast_write: assert property (
        wr_drive |=> contrast_code == $past(hwdata[lcd_pkg::CONTRAST_LSB +: 6]))
        else $error("Contrast output does not follow the written field.");
    chk_doze_resume: assert property (
        ($fell(st_r.doze) && !st_r.halt && st_r.osc_stable) |-> ##[0:1] drive_enable)
        else $error("Drive did not resume after doze cleared.");

    cov_center_band: cover property (st_r.duty == lcd_pkg::DUTY_BAND && st_r.center && |row_drive_outputs);
    cov_halt_restart: cover property ($rose(st_r.osc_stable) && st_r.halt);
    cov_doze_off: cover property (st_r.doze && !drive_power_on);
    cov_frame: cover property (sc.frame_strobe && st_r.duty == lcd_pkg::DUTY_FULL);

endmodule : lcd_ctrl

`default_nettype wire

/* File: core/lcd_pkg.sv */
// Purpose: Shared constants for the LCD drive controller.
// Assumes: hclk runs at 25 MHz; the panel oscillator is nominally 70 kHz.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none

package lcd_pkg;

    // ****************************************************************
    // Timing base
    // ****************************************************************
    localparam int unsigned HCLK_HZ       = 25_000_000;
    localparam int unsigned OSC_HZ        = 70_000;
    localparam int unsigned FRAME_HZ      = 68;
    localparam int unsigned HCLK_PER_OSC  = HCLK_HZ / OSC_HZ;
    localparam int unsigned OSC_PER_FRAME = OSC_HZ / FRAME_HZ;
    localparam logic [8:0]  OSC_DIV_LAST  = 9'(HCLK_PER_OSC - 1);
    localparam logic [10:0] FRAME_TICKS   = 11'(OSC_PER_FRAME);

    // ****************************************************************
    // Panel geometry
    // ****************************************************************
    localparam int unsigned PANEL_ROWS  = 128;
    localparam logic [7:0]  FULL_ROWS   = 8'h78;
    localparam int unsigned BAND_ROWS   = 16;
    localparam int unsigned BAND_CENTER = (120 - BAND_ROWS) / 2;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_DRIVE  = 12'h000;
    localparam logic [11:0] ADDR_POWER  = 12'h004;
    localparam logic [11:0] ADDR_CMD    = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [2:0]  SIZE_WORD   = 3'h2;

    // Drive configuration fields.
    localparam int unsigned DUTY_LSB     = 0;
    localparam int unsigned BIAS_LSB     = 4;
    localparam int unsigned BOOST_LSB    = 8;
    localparam int unsigned CENTER_BIT   = 12;
    localparam int unsigned CONTRAST_LSB = 16;
    // Power control fields.
    localparam int unsigned DOZE_BIT     = 0;
    localparam int unsigned HALT_BIT     = 1;
    localparam int unsigned AMP_LSB      = 2;
    // Command and status fields.
    localparam int unsigned START_OSC_BIT = 0;
    localparam int unsigned ST_OSC_RUN    = 0;
    localparam int unsigned ST_OSC_STABLE = 1;
    localparam int unsigned ST_DRIVE      = 2;
    localparam int unsigned ST_POWER      = 3;
    localparam int unsigned ST_FRAME      = 4;
    localparam int unsigned ST_ROW_LSB    = 8;

    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [3:0] DUTY_FULL    = 4'hE;
    localparam logic [3:0] DUTY_BAND    = 4'h1;
    localparam logic [2:0] BIAS_NORMAL  = 3'h0;
    localparam logic [2:0] BIAS_PARTIAL = 3'h6;
    localparam logic [1:0] BOOST_X6     = 2'h2;
    localparam logic [1:0] BOOST_X2     = 2'h0;
    localparam logic [1:0] AMP_OFF      = 2'h0;
    localparam logic [5:0] CONTRAST_RST = 6'h00;
    localparam logic [1:0] AMP_RST      = 2'h1;

    // Rows scanned per frame for a duty code: eight rows per step.
    function automatic logic [7:0] duty_rows(input logic [3:0] code);
        duty_rows = {1'b0, code, 3'h0} + 8'h08;
    endfunction : duty_rows

endpackage : lcd_pkg

`default_nettype wire

/* File: core/scan_if.sv */
// Purpose: Carries scan control between the controller and the row scanner.
// Assumes: Both ends run on hclk.
// Notes:   The scanner reports the logical row inside the driven band.
`default_nettype none

interface scan_if;
    logic       tick;
    logic       enable;
    logic [7:0] nrows;
    logic [6:0] row;
    logic       frame_strobe;

    modport ctrl (output tick, output enable, output nrows, input row, input frame_strobe);
    modport gen  (input tick, input enable, input nrows, output row, output frame_strobe);
endinterface : scan_if

`default_nettype wire

/* File: core/row_scan.sv */
// Purpose: Row scanner pacing one frame per fixed count of oscillator ticks.
// Assumes: tick is a one-cycle pulse; nrows is between 8 and 128.
// Notes:   A fractional accumulator keeps the frame rate fixed for any duty.
`default_nettype none

module row_scan (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Scan control
    scan_if.gen       sc
);

    typedef struct packed {
        logic [10:0] acc;
        logic [6:0]  row;
        logic        frame;
    } scan_state_t;

    scan_state_t st_r;
    scan_state_t st_nxt;
    logic [11:0] sum;

    // ****************************************************************
    // Row and frame stepping
    // ****************************************************************
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.frame = 1'b0;
        sum          = {1'b0, st_r.acc} + {4'h0, sc.nrows};
        if (!sc.enable)
        begin
            st_nxt = '0;
        end
        else if (sc.tick)
        begin
            // Each frame with an unchanged row count lasts exactly the frame tick count, so the rate holds at every duty.
            if (sum >= {1'b0, lcd_pkg::FRAME_TICKS})
            begin
                st_nxt.acc = 11'(sum - {1'b0, lcd_pkg::FRAME_TICKS});
                if (({1'b0, st_r.row} + 8'h01) >= sc.nrows)
                begin
                    st_nxt.row   = 7'h00;
                    st_nxt.frame = 1'b1;
                end
                else
                begin
                    st_nxt.row = st_r.row + 7'h01;
                end
            end
            else
            begin
                st_nxt.acc = sum[10:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sc.row          = st_r.row;
    assign sc.frame_strobe = st_r.frame;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [10:0] chk_ticks;
    logic        chk_clean;
    logic [7:0]  chk_nrows;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chk_ticks <= '0;
            chk_clean <= 1'b0;
            chk_nrows <= '0;
        end
        else
        begin
            chk_nrows <= sc.nrows;
            if (!sc.enable || st_r.frame)
                chk_ticks <= '0;
            else if (sc.tick)
                chk_ticks <= chk_ticks + 11'h001;
            chk_clean <= (!sc.enable || st_r.frame || chk_clean) && (sc.nrows == chk_nrows);
        end
    end

    chk_frame_period: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.frame && chk_clean) |-> chk_ticks == lcd_pkg::FRAME_TICKS)
        else $error("Frame length differs from the fixed tick count.");

endmodule : row_scan

`default_nettype wire

/* File: verification/ahb_host.sv */
// Purpose: AHB-Lite host model issuing single word transfers to the LCD controller.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes:   Each phase is sampled at the falling edge before the rising edge that ends it.
`default_nettype none

module ahb_host (
    // Clock
    input  wire logic        hclk,
    // Master request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    // Slave answer
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = lcd_pkg::SIZE_WORD;
        hwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        logic rdy;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        do
        begin
            @(negedge hclk);
            rdy = hready;
            @(posedge hclk);
        end
        while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~addr;
        hwdata <= wdata;
        do
        begin
            @(negedge hclk);
            rdy   = hready;
            rdata = hrdata;
            @(posedge hclk);
        end
        while (rdy !== 1'b1);
        // Released data is inverted so a stale value never passes for a live one.
        hwdata <= ~wdata;
    endtask : xfer
endmodule : ahb_host

`default_nettype wire

/* File: verification/test_lcd_partial_drive_power_modes.sv */
// Purpose: Self-checking bench for partial display, doze and deep halt control.
// Assumes: OSC_SETTLE_CLKS is 8; a full frame is too long to run here.
// Notes:   Outputs are judged at the falling edge after each register write.
`default_nettype none

module test_lcd_partial_drive_power_modes;
    timeunit 1ns;
    timeprecision 1ps;

    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, drive_enable, drive_power_on, osc_running;
    logic [1:0]   htrans, boost_code;
    logic [2:0]   hsize, bias_code;
    logic [5:0]   contrast_code;
    logic [31:0]  haddr, hwdata, hrdata, rv;
    logic [127:0] row_drive_outputs;
    int           err_total, num_checks;

    lcd_ctrl #(.OSC_SETTLE_CLKS(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .row_drive_outputs(row_drive_outputs),
        .drive_enable(drive_enable), .drive_power_on(drive_power_on), .bias_code(bias_code),
        .boost_code(boost_code), .contrast_code(contrast_code), .osc_running(osc_running));
    ahb_host host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(a, 1'b1, d, x);
        @(negedge hclk);
    endtask : wr

    task automatic t_reset();
        check(128'(bias_code), 128'(lcd_pkg::BIAS_NORMAL), "bias");
        check(128'(boost_code), 128'(lcd_pkg::BOOST_X6), "boost");
        check(128'(contrast_code), 128'h0, "contrast");
        host_u.xfer(32'(lcd_pkg::ADDR_DRIVE), 1'b0, 32'h0, rv);
        check(128'(rv), 128'h0000_020E, "drive reset");
        host_u.xfer(32'h0000_0010, 1'b0, 32'h0, rv);
        check(128'(rv), 128'h0, "unmapped read");
    endtask : t_reset

    // Doze in and out restarts the scan, so the first row lands on the band start.
    task automatic t_band(input logic ctr, input int start, input logic [1:0] amp);
        logic [127:0] bad;
        logic [31:0]  d;
        d = {10'h0, 6'h2A, 3'h0, ctr, 2'h0, lcd_pkg::BOOST_X2, 1'b0, lcd_pkg::BIAS_PARTIAL, lcd_pkg::DUTY_BAND};
        wr(32'(lcd_pkg::ADDR_DRIVE), d);
        check(128'(bias_code), 128'(lcd_pkg::BIAS_PARTIAL), "bias");
        check(128'(boost_code), 128'(lcd_pkg::BOOST_X2), "boost");
        check(128'(contrast_code), 128'h2A, "contrast");
        host_u.xfer(32'(lcd_pkg::ADDR_DRIVE), 1'b0, 32'h0, rv);
        check(128'(rv), 128'(d), "drive readback");
        wr(32'(lcd_pkg::ADDR_POWER), {28'h0, amp, 2'b01});
        check(128'({drive_enable, osc_running}), 128'h1, "doze drive and osc");
        check(row_drive_outputs, 128'h0, "doze rows");
        check(128'(drive_power_on), 128'(amp != 2'b00), "doze power");
        wr(32'(lcd_pkg::ADDR_POWER), 32'h0000_0004);
        check(128'(drive_enable), 128'h1, "resume");
        @(negedge hclk);
        check(row_drive_outputs, 128'h1 << start, "band start");
        bad = 128'h0;
        repeat (300)
        begin
            @(negedge hclk);
            bad = bad | (row_drive_outputs & ~(128'hFFFF << start));
        end
        check(bad, 128'h0, "rows outside band");
    endtask : t_band

    task automatic t_halt();
        int n;
        wr(32'(lcd_pkg::ADDR_POWER), 32'h0000_0002);
        check(128'(osc_running), 128'h0, "halt osc");
        check(128'(drive_enable) | row_drive_outputs, 128'h0, "halt outputs");
        check(128'(drive_power_on), 128'h0, "halt power");
        wr(32'(lcd_pkg::ADDR_DRIVE), 32'h0000_020E);
        check(128'(bias_code), 128'(lcd_pkg::BIAS_PARTIAL), "ignored drive write");
        wr(32'(lcd_pkg::ADDR_POWER), 32'h0000_0004);
        host_u.xfer(32'(lcd_pkg::ADDR_POWER), 1'b0, 32'h0, rv);
        check(128'(rv), 128'h2, "ignored power write");
        check(128'({hreadyout, hresp}), 128'h2, "ignored write answer");
        wr(32'(lcd_pkg::ADDR_CMD), 32'h0000_0001);
        n = 0;
        rv = 32'h0;
        while (rv[lcd_pkg::ST_OSC_STABLE] !== 1'b1 && n < 40)
        begin
            host_u.xfer(32'(lcd_pkg::ADDR_STATUS), 1'b0, 32'h0, rv);
            n++;
        end
        check(128'({rv[lcd_pkg::ST_OSC_STABLE], osc_running}), 128'h3, "restart");
        wr(32'(lcd_pkg::ADDR_POWER), 32'h0000_0004);
        check(128'(drive_enable), 128'h1, "halt left");
        wr(32'(lcd_pkg::ADDR_DRIVE), 32'h0000_020E);
        check(128'(bias_code), 128'(lcd_pkg::BIAS_NORMAL), "drive write accepted");
    endtask : t_halt

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial
    begin
        repeat (20000) @(posedge hclk);
        err_total++;
        end_of_test();
    end

    initial
    begin
        err_total = 0;
        num_checks = 0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        t_reset();
        t_band(1'b1, lcd_pkg::BAND_CENTER, 2'b00);
        t_band(1'b0, 0, 2'b01);
        t_halt();
        end_of_test();
    end
endmodule : test_lcd_partial_drive_power_modes

`default_nettype wire
